// file: logic/fmpr_device.sv
// device end: load port latches, third-order modulator, resync timer
// ==========================================================
module fmpr_device (
  // system
  input  wire logic        clk,
  input  wire logic        nrst,
  // link
  fmpr_if.device           link,
  // modulator output
  output logic [12:0]      int_value,
  output logic signed [3:0] frac_offset,
  output logic             cmp_tick,
  // phase resync, fast lock and dither state
  output logic             sync_pulse,
  output logic             realign_pulse,
  output logic             fast_lock_active,
  output logic             dither_on
);
  logic [fmpr_pkg::WORD_W-1:0] shift_ff;
  logic [fmpr_pkg::WORD_W-1:0] freq_ff, phase_ff, modref_ff, func_ff, cdiv_ff;
  logic                      sclk_d_ff, le_d_ff;
  logic                      sclk_rise, le_rise;
  logic [2:0]                addr;
  logic                      ld_freq, ld_phase, ld_modref, ld_func, ld_cdiv;

  // ==========================================================
  // serial input register and latch decode
  assign sclk_rise = link.sclk & ~sclk_d_ff;
  assign le_rise = link.latch_load_strobe & ~le_d_ff;
  assign addr = shift_ff[fmpr_pkg::ADDR_MSB:fmpr_pkg::ADDR_LSB];

  function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
    hit = (a == target);
  endfunction

  assign ld_freq = le_rise & hit(addr, fmpr_pkg::ADDR_FREQ);
  assign ld_phase = le_rise & hit(addr, fmpr_pkg::ADDR_PHASE);
  assign ld_modref = le_rise & hit(addr, fmpr_pkg::ADDR_MODREF);
  assign ld_func = le_rise & hit(addr, fmpr_pkg::ADDR_FUNC);
  assign ld_cdiv = le_rise & hit(addr, fmpr_pkg::ADDR_CLKDIV);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_ff <= 1'b0;
      le_d_ff <= 1'b0;
      shift_ff <= '0;
    end else begin
      sclk_d_ff <= link.sclk;
      le_d_ff <= link.latch_load_strobe;
      if (sclk_rise) begin
        shift_ff <= {shift_ff[fmpr_pkg::WORD_W-2:0], link.sdata};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freq_ff <= '0;
      phase_ff <= '0;
      modref_ff <= '0;
      func_ff <= '0;
      cdiv_ff <= '0;
    end else begin
      if (ld_freq) freq_ff <= shift_ff;
      if (ld_phase) phase_ff <= shift_ff;
      if (ld_modref) modref_ff <= shift_ff;
      if (ld_func) func_ff <= shift_ff;
      if (ld_cdiv) cdiv_ff <= shift_ff;
    end
  end

  // ==========================================================
  // field extraction
  logic [11:0] mod_raw, modulus, frac_word, phase_word, cdiv_raw, cdiv_val;
  logic [1:0]  cd_mode;
  logic        sd_reset_bit, resync_mode, fastlock_mode;

  assign mod_raw = modref_ff[fmpr_pkg::F12_MSB:fmpr_pkg::F12_LSB];
  assign modulus = (mod_raw < fmpr_pkg::MOD_MIN) ? fmpr_pkg::MOD_MIN : mod_raw;
  assign frac_word = freq_ff[fmpr_pkg::F12_MSB:fmpr_pkg::F12_LSB];
  assign phase_word = phase_ff[fmpr_pkg::F12_MSB:fmpr_pkg::F12_LSB];
  assign int_value = freq_ff[fmpr_pkg::INT_MSB:fmpr_pkg::INT_LSB];
  assign sd_reset_bit = func_ff[fmpr_pkg::SD_RESET_BIT];
  assign dither_on = func_ff[fmpr_pkg::DITHER_BIT];
  assign cdiv_raw = cdiv_ff[fmpr_pkg::CDIV_MSB:fmpr_pkg::CDIV_LSB];
  assign cdiv_val = (cdiv_raw < fmpr_pkg::CDIV_MIN) ? fmpr_pkg::CDIV_MIN : cdiv_raw;
  assign cd_mode = cdiv_ff[fmpr_pkg::CDMODE_MSB:fmpr_pkg::CDMODE_LSB];
  assign resync_mode = (cd_mode == fmpr_pkg::CDMODE_RESYNC);
  assign fastlock_mode = (cd_mode == fmpr_pkg::CDMODE_FASTLOCK);

  // ==========================================================
  // comparison-rate enable from the system clock
  logic [3:0] cmp_cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_cnt_ff <= 4'h0;
    end else if (cmp_tick) begin
      cmp_cnt_ff <= 4'h0;
    end else begin
      cmp_cnt_ff <= cmp_cnt_ff + 4'h1;
    end
  end
  assign cmp_tick = (cmp_cnt_ff == 4'(fmpr_pkg::CMP_DIV - 1));

  // ==========================================================
  // third-order cascaded modulator, accumulators modulo the modulus
  logic [11:0] acc1_ff, acc2_ff, acc3_ff;
  logic [11:0] nxt_acc1, nxt_acc2, nxt_acc3;
  logic        c1, c2, c3, c2_d_ff, c3_d_ff, c3_dd_ff;
  logic [fmpr_pkg::DITHER_W-1:0] lfsr_ff;
  logic        lfsr_fb, restart;

  function automatic logic [12:0] mod_add(input logic [11:0] a, input logic [11:0] b,
                                          input logic [11:0] m);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m}) begin
      mod_add = {1'b1, 12'(s - {1'b0, m})};
    end else begin
      mod_add = {1'b0, s[11:0]};
    end
  endfunction

  // dither adds a 2^21-period sequence to the first stage
  assign {c1, nxt_acc1} = mod_add(acc1_ff, frac_word + {11'h000, dither_on & lfsr_ff[0]}, modulus);
  assign {c2, nxt_acc2} = mod_add(acc2_ff, nxt_acc1, modulus);
  assign {c3, nxt_acc3} = mod_add(acc3_ff, nxt_acc2, modulus);
  // de Bruijn extension of a 21-bit LFSR covers all 2^21 states
  assign lfsr_fb = lfsr_ff[fmpr_pkg::DITHER_W-1] ^ lfsr_ff[fmpr_pkg::DITHER_TAP-1]
                   ^ (lfsr_ff[fmpr_pkg::DITHER_W-2:0] == '0);
  assign restart = (ld_freq & ~sd_reset_bit) | realign_pulse;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc1_ff <= 12'h000;
      acc2_ff <= 12'h000;
      acc3_ff <= 12'h000;
      c2_d_ff <= 1'b0;
      c3_d_ff <= 1'b0;
      c3_dd_ff <= 1'b0;
      frac_offset <= 4'sh0;
    end else if (restart) begin
      acc1_ff <= (phase_word >= modulus) ? 12'h000 : phase_word;
      acc2_ff <= 12'h000;
      acc3_ff <= 12'h000;
      c2_d_ff <= 1'b0;
      c3_d_ff <= 1'b0;
      c3_dd_ff <= 1'b0;
    end else if (cmp_tick) begin
      acc1_ff <= nxt_acc1;
      acc2_ff <= nxt_acc2;
      acc3_ff <= nxt_acc3;
      c2_d_ff <= c2;
      c3_d_ff <= c3;
      c3_dd_ff <= c3_d_ff;
      frac_offset <= 4'(signed'({3'h0, c1}) + signed'({3'h0, c2}) - signed'({3'h0, c2_d_ff})
                     + signed'({3'h0, c3}) - 4'sh2 * signed'({3'h0, c3_d_ff})
                     + signed'({3'h0, c3_dd_ff}));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_ff <= '0;
    end else if (cmp_tick & dither_on) begin
      lfsr_ff <= {lfsr_ff[fmpr_pkg::DITHER_W-2:0], lfsr_fb};
    end
  end

  // ==========================================================
  // sync timer: divider times modulus comparison periods
  logic [11:0] mcnt_ff, dcnt_ff;
  logic        mwrap, dwrap;
  logic [1:0]  pend_ff;
  logic [11:0] fl_cnt_ff;

  assign mwrap = (mcnt_ff >= modulus - 12'h001);
  assign dwrap = (dcnt_ff >= cdiv_val - 12'h001);
  assign sync_pulse = resync_mode & cmp_tick & mwrap & dwrap;
  assign realign_pulse = sync_pulse & (pend_ff == 2'h1);
  assign fast_lock_active = (fl_cnt_ff != 12'h000);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcnt_ff <= 12'h000;
      dcnt_ff <= 12'h000;
    end else if (~resync_mode) begin
      mcnt_ff <= 12'h000;
      dcnt_ff <= 12'h000;
    end else if (cmp_tick) begin
      mcnt_ff <= mwrap ? 12'h000 : mcnt_ff + 12'h001;
      dcnt_ff <= mwrap ? (dwrap ? 12'h000 : dcnt_ff + 12'h001) : dcnt_ff;
    end
  end

  // a load in the same cycle as a sync restarts the count of two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= 2'h0;
    end else if (~resync_mode) begin
      pend_ff <= 2'h0;
    end else if (ld_freq) begin
      pend_ff <= fmpr_pkg::SYNC_TO_REALIGN;
    end else if (sync_pulse && pend_ff != 2'h0) begin
      pend_ff <= pend_ff - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fl_cnt_ff <= 12'h000;
    end else if (~fastlock_mode) begin
      fl_cnt_ff <= 12'h000;
    end else if (ld_freq) begin
      fl_cnt_ff <= cdiv_val;
    end else if (cmp_tick && fast_lock_active) begin
      fl_cnt_ff <= fl_cnt_ff - 12'h001;
    end
  end
endmodule

// file: logic/fmpr_host.sv
// host end: shifts one 29-bit word out, then strobes the latch load
module fmpr_host (
  // system
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // link
  fmpr_if.host                             link,
  // user side
  input  wire logic                        wr_valid,
  input  wire logic [fmpr_pkg::WORD_W-1:0] wr_word,
  output logic                             wr_ready
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_LOAD} fmpr_hstate_t;
  fmpr_hstate_t              state_ff, nxt_state;
  logic [fmpr_pkg::WORD_W-1:0] sh_ff, nxt_sh;
  logic [4:0]                bit_ff, nxt_bit;
  logic [3:0]                tick_ff;
  logic                      half_done;
  logic                      sclk_ff, nxt_sclk, le_ff, nxt_le;

  // ==========================================================
  // half-period pacing keeps the shift clock at 10 MHz
  assign half_done = (tick_ff == 4'(fmpr_pkg::SCLK_HALF - 1));
  assign wr_ready = (state_ff == S_IDLE);
  assign link.sclk = sclk_ff;
  assign link.sdata = sh_ff[fmpr_pkg::WORD_W-1];
  assign link.latch_load_strobe = le_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_sclk = sclk_ff;
    nxt_le = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (wr_valid) begin
          nxt_sh = wr_word;
          nxt_bit = 5'(fmpr_pkg::WORD_W - 1);
          nxt_state = S_LOW;
        end
      end
      S_LOW: begin
        if (half_done) begin
          nxt_sclk = 1'b1;
          nxt_state = S_HIGH;
        end
      end
      S_HIGH: begin
        if (half_done) begin
          nxt_sclk = 1'b0;
          if (bit_ff == 5'h00) begin
            nxt_le = 1'b1;
            nxt_state = S_LOAD;
          end else begin
            nxt_sh = {sh_ff[fmpr_pkg::WORD_W-2:0], 1'b0}; // msb first, 29 bits
            nxt_bit = bit_ff - 5'h01;
            nxt_state = S_LOW;
          end
        end
      end
      S_LOAD: begin
        nxt_le = ~half_done;
        if (half_done) begin
          nxt_state = S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= S_IDLE;
      sh_ff <= '0;
      bit_ff <= 5'h00;
      sclk_ff <= 1'b0;
      le_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      sclk_ff <= nxt_sclk;
      le_ff <= nxt_le;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 4'h0;
    end else if (state_ff == S_IDLE || half_done) begin
      tick_ff <= 4'h0;
    end else begin
      tick_ff <= tick_ff + 4'h1;
    end
  end
endmodule

// file: logic/fmpr_if.sv
// three-wire load port joining host and synthesizer control core
interface fmpr_if;
  logic sclk;
  logic sdata;
  logic latch_load_strobe;
  modport host (output sclk, output sdata, output latch_load_strobe);
  modport device (input sclk, input sdata, input latch_load_strobe);
endinterface

// file: logic/fmpr_pkg.sv
// constants shared by both ends of the fractional modulator load port
package fmpr_pkg;
  // ==========================================================
  // word and latch addressing
  localparam int unsigned WORD_W = 29;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_MSB = 2;
  localparam logic [2:0] ADDR_FREQ = 3'h0;
  localparam logic [2:0] ADDR_PHASE = 3'h1;
  localparam logic [2:0] ADDR_MODREF = 3'h2;
  localparam logic [2:0] ADDR_FUNC = 3'h3;
  localparam logic [2:0] ADDR_CLKDIV = 3'h4;
  // ==========================================================
  // field positions
  localparam int unsigned F12_LSB = 3;
  localparam int unsigned F12_MSB = 14;
  localparam int unsigned INT_LSB = 15;
  localparam int unsigned INT_MSB = 27;
  localparam int unsigned SD_RESET_BIT = 14;
  localparam int unsigned DITHER_BIT = 3;
  localparam int unsigned CDIV_LSB = 7;
  localparam int unsigned CDIV_MSB = 18;
  localparam int unsigned CDMODE_LSB = 19;
  localparam int unsigned CDMODE_MSB = 20;
  // ==========================================================
  // values and modes
  localparam logic [11:0] MOD_MIN = 12'h002;
  localparam logic [11:0] MOD_DITHER_MIN = 12'h032;
  localparam logic [11:0] CDIV_MIN = 12'h001;
  localparam logic [1:0] CDMODE_FASTLOCK = 2'h1;
  localparam logic [1:0] CDMODE_RESYNC = 2'h2;
  localparam logic [1:0] SYNC_TO_REALIGN = 2'h2;
  localparam int unsigned DITHER_W = 21;
  localparam int unsigned DITHER_TAP = 19;
  // ==========================================================
  // timing: 40 MHz system clock
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CMP_HZ = 20000000;
  localparam int unsigned CMP_DIV = CLK_HZ / CMP_HZ;
  localparam int unsigned SCLK_MAX_HZ = 20000000;
  localparam int unsigned SCLK_HZ = 10000000;
  localparam int unsigned SCLK_HALF = (CLK_HZ + 2 * SCLK_HZ - 1) / (2 * SCLK_HZ);
endpackage

// file: testbench/fmpr_link_assertions.sv
// checker for the three-wire load port between host and device
module fmpr_link_chk (
  // system
  input wire logic clk,
  input wire logic nrst,
  // link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper: shift clock rises since the last strobe
  logic       sclk_q_ff;
  logic [5:0] bit_cnt_ff;
  logic [5:0] nxt_bit_cnt;
  wire        sclk_rise = sclk & ~sclk_q_ff;
  assign nxt_bit_cnt = latch_load_strobe ? 6'h00 : (sclk_rise ? bit_cnt_ff + 6'h01 : bit_cnt_ff);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q_ff  <= 1'b0;
      bit_cnt_ff <= 6'h00;
    end else begin
      sclk_q_ff  <= sclk;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence sclk_high_s;
    sclk ##1 sclk ##1 !sclk;
  endsequence
  sequence strobe_pulse_s;
    latch_load_strobe ##1 latch_load_strobe ##1 !latch_load_strobe;
  endsequence
  strobe_sclk_low_a: assert property (latch_load_strobe |-> !sclk)
    else $error("strobe high while shift clock high");
  sclk_high_len_a: assert property ($rose(sclk) |-> sclk_high_s)
    else $error("shift clock high phase not two cycles");
  sclk_low_len_a: assert property ($fell(sclk) |=> !sclk)
    else $error("shift clock low phase too short");
  sclk_spacing_a: assert property ($rose(sclk) |=> !$rose(sclk) [*3])
    else $error("shift clock rises too close");
  data_hold_a: assert property (sclk |-> $stable(sdata))
    else $error("data moved while shift clock high");
  strobe_len_a: assert property ($rose(latch_load_strobe) |-> strobe_pulse_s)
    else $error("strobe pulse not two cycles");
  word_bits_a: assert property ($rose(latch_load_strobe) |-> bit_cnt_ff == 6'h1d)
    else $error("strobe after wrong bit count");
  strobe_follows_a: assert property ($fell(sclk) && bit_cnt_ff == 6'h1d |-> ##[0:4] latch_load_strobe)
    else $error("no strobe after last bit");
endmodule

// file: testbench/testbench.sv
// self-checking bench: host and device joined over the load port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 2;
  logic clk = 1'b0;
  logic nrst, wr_valid, wr_ready, cmp_tick, sync_pulse, realign_pulse, fast_lock_active, dither_on;
  logic [28:0] wr_word;
  logic [28:0] cap_sr = '0;
  logic [28:0] cap_word = '0;
  logic [12:0] int_value;
  logic signed [3:0] frac_offset;
  logic sclk_q = 1'b0;
  logic stb_q = 1'b0;
  int n_sync = 0, n_real = 0, real_at = 0, fl_ticks = 0;
  int bad_count, checks_done;
  fmpr_if link();
  fmpr_host i_fmpr_host (.clk(clk), .nrst(nrst), .link(link.host), .wr_valid(wr_valid),
    .wr_word(wr_word), .wr_ready(wr_ready));
  fmpr_device i_fmpr_device (.clk(clk), .nrst(nrst), .link(link.device), .int_value(int_value),
    .frac_offset(frac_offset), .cmp_tick(cmp_tick), .sync_pulse(sync_pulse),
    .realign_pulse(realign_pulse), .fast_lock_active(fast_lock_active), .dither_on(dither_on));
  fmpr_link_chk i_fmpr_link_chk (.clk(clk), .nrst(nrst), .sclk(link.sclk), .sdata(link.sdata),
    .latch_load_strobe(link.latch_load_strobe));
  always #12.5 clk = ~clk;
  // ==========================================================
  // wire monitor: captured word and event counts since each strobe
  always @(posedge clk) begin
    sclk_q <= link.sclk;
    stb_q <= link.latch_load_strobe;
    if (link.sclk && !sclk_q) cap_sr <= {cap_sr[27:0], link.sdata};
    if (link.latch_load_strobe && !stb_q) begin
      cap_word <= cap_sr;
      n_sync <= 0;
      n_real <= 0;
      fl_ticks <= 0;
    end else begin
      if (sync_pulse === 1'b1) n_sync <= n_sync + 1;
      if (realign_pulse === 1'b1) n_real <= n_real + 1;
      if (realign_pulse === 1'b1) real_at <= n_sync + (sync_pulse === 1'b1 ? 1 : 0);
      if (fast_lock_active === 1'b1 && cmp_tick === 1'b1) fl_ticks <= fl_ticks + 1;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (wr_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      #DLY;
      n++;
    end
  endtask
  task automatic send(logic [28:0] w);
    wait_ready();
    wr_word = w;
    wr_valid = 1'b1;
    @(posedge clk);
    #DLY;
    wr_valid = 1'b0;
    wait_ready();
    repeat (3) @(posedge clk);
    #DLY;
    check("wire word", {3'h0, w}, {3'h0, cap_word});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_addr();
    send({1'b0, 13'h0abc, 12'h001, fmpr_pkg::ADDR_FREQ});
    check("int value", 32'h0abc, {19'h0, int_value});
    send({1'b0, 13'h1fff, 12'h000, 3'h7});
    check("int kept", 32'h0abc, {19'h0, int_value});
    send({14'h0, fmpr_pkg::MOD_DITHER_MIN, fmpr_pkg::ADDR_MODREF});
    send({14'h0, 1'b0, 10'h0, 1'b1, fmpr_pkg::ADDR_FUNC});
    check("dither on", 32'h1, {31'h0, dither_on});
    send({26'h0, fmpr_pkg::ADDR_FUNC});
    check("dither off", 32'h0, {31'h0, dither_on});
    $display("test addressing done");
  endtask
  task automatic t_repeat(logic [11:0] m, int len);
    logic signed [3:0] v[$];
    int errs, sum, n;
    errs = 0;
    sum = 0;
    n = 0;
    send({14'h0, m, fmpr_pkg::ADDR_MODREF});
    send({1'b0, 13'h0010, 12'h001, fmpr_pkg::ADDR_FREQ});
    while (v.size() < 8 + 2 * len && n < 4000) begin
      @(posedge clk);
      #DLY;
      n++;
      if (cmp_tick === 1'b1) v.push_back(frac_offset);
    end
    for (int i = 8; i < 8 + len; i++) begin
      sum += int'(v[i]);
      if (v[i] !== v[i + len]) errs++;
    end
    check("repeat errors", 0, errs);
    check("offset sum", len / int'(m), sum);
    $display("test repeat length %0d done", len);
  endtask
  task automatic t_resync();
    int ticks, n;
    ticks = 0;
    n = 0;
    send({14'h0, 12'h003, fmpr_pkg::ADDR_MODREF});
    send({8'h0, fmpr_pkg::CDMODE_RESYNC, 12'h002, 4'h0, fmpr_pkg::ADDR_CLKDIV});
    send({1'b0, 13'h0010, 12'h001, fmpr_pkg::ADDR_FREQ});
    repeat (80) @(posedge clk);
    #DLY;
    check("realign count", 1, n_real);
    check("realign sync", 2, real_at);
    while (sync_pulse !== 1'b1 && n < 100) begin
      @(posedge clk);
      #DLY;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #DLY;
      n++;
      if (cmp_tick === 1'b1) ticks++;
    end while (sync_pulse !== 1'b1 && n < 100);
    check("sync period", 6, ticks);
    $display("test resync done");
  endtask
  task automatic t_fastlock();
    send({8'h0, fmpr_pkg::CDMODE_FASTLOCK, 12'h005, 4'h0, fmpr_pkg::ADDR_CLKDIV});
    send({1'b0, 13'h0010, 12'h001, fmpr_pkg::ADDR_FREQ});
    repeat (80) @(posedge clk);
    #DLY;
    check("fast lock ticks", 5, fl_ticks);
    check("no realign", 0, n_real);
    check("no sync", 0, n_sync);
    $display("test fast lock done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    nrst = 1'b0;
    wr_valid = 1'b0;
    wr_word = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    #DLY;
    nrst = 1'b1;
    t_addr();
    t_repeat(12'h002, 4);
    t_repeat(12'h003, 9);
    t_repeat(12'h005, 5);
    t_repeat(12'h006, 36);
    t_resync();
    t_fastlock();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule
